// *** bench/cls_far_end_model.sv ***
// far-end model: fieldbus option, serial master, keypad and panel-port traffic sources
`timescale 1ns/1ps

module cls_far_end_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] quiet,
    input wire logic [7:0] gap,
    output logic fb_activity,
    output logic serial_activity,
    output logic keypad_present,
    output logic cp_activity
);
    logic [7:0] cnt_q;
    logic beat;

    // a gap of zero means traffic every cycle, larger gaps model a slow peer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= gap) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign beat = (cnt_q == 8'h00);
    // a silenced path shows no pulses at all; the keypad path gives a presence level, not pulses
    assign fb_activity = beat & ~quiet[0];
    assign serial_activity = beat & ~quiet[1];
    assign keypad_present = ~quiet[2];
    assign cp_activity = beat & ~quiet[3];
endmodule

// *** bench/tb.sv ***
// testbench: supervisor driven over its register port against the far-end traffic model
`timescale 1ns/1ps

module tb;
    localparam int TICK = 4;
    typedef struct packed {
        logic [14:0] ctrl;
        logic [3:0] quiet;
        logic [2:0] exp;
    } cls_tb_row_t;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic fb_net_error = 1'b0;
    cls_pkg::cls_cp_cmd_t cp_cmd = 4'h0;
    logic drive_running = 1'b0;
    logic [3:0] quiet = 4'h0;
    logic [7:0] gap = 8'h00;
    logic fb_activity, serial_activity, keypad_present, cp_activity;
    logic fb_iface_enable, serial_iface_enable, loss_trip, loss_warning, pset_change;
    logic stop_request, irq;
    logic [1:0] pset_sel;
    int failures = 0;
    int checks = 0;
    logic [7:0] offs [0:3] = '{8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0] dflt [0:3] = '{8'h05, 8'h05, 8'h14, 8'h64};
    // ctrl, silenced path {panel,keypad,serial,fb}, expected {trip,warning,set change}
    cls_tb_row_t rows [0:18] = '{
        '{15'h1501, 4'h1, 3'h4}, '{15'h1502, 4'h1, 3'h2}, '{15'h5503, 4'h1, 3'h3},
        '{15'h1500, 4'h1, 3'h0}, '{15'h1401, 4'h1, 3'h0}, '{15'h0101, 4'h1, 3'h0},
        '{15'h1404, 4'h2, 3'h4}, '{15'h1408, 4'h2, 3'h2}, '{15'h540C, 4'h2, 3'h3},
        '{15'h1400, 4'h2, 3'h0}, '{15'h0004, 4'h2, 3'h0}, '{15'h0010, 4'h4, 3'h4},
        '{15'h0020, 4'h4, 3'h2}, '{15'h0000, 4'h4, 3'h0}, '{15'h0030, 4'h4, 3'h0},
        '{15'h1440, 4'h8, 3'h4}, '{15'h1480, 4'h8, 3'h2}, '{15'h54C0, 4'h8, 3'h3},
        '{15'h1400, 4'h8, 3'h0}};

    always #10 clk = ~clk;

    cls_supervisor #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fb_activity(fb_activity), .fb_net_error(fb_net_error),
        .serial_activity(serial_activity), .keypad_present(keypad_present),
        .cp_activity(cp_activity), .cp_cmd(cp_cmd), .drive_running(drive_running),
        .fb_iface_enable(fb_iface_enable), .serial_iface_enable(serial_iface_enable),
        .loss_trip(loss_trip), .loss_warning(loss_warning), .pset_change(pset_change),
        .pset_sel(pset_sel), .stop_request(stop_request), .irq(irq));

    cls_far_end_model far_end (.clk(clk), .sys_rst(sys_rst), .quiet(quiet), .gap(gap),
        .fb_activity(fb_activity), .serial_activity(serial_activity),
        .keypad_present(keypad_present), .cp_activity(cp_activity));

    task automatic finish_test();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so it is sampled there
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    task automatic acts(input string name, input logic [2:0] exp);
        chk(name, {29'h0, exp}, {29'h0, loss_trip, loss_warning, pset_change});
    endtask

    task automatic run_row(input cls_tb_row_t r);
        wr(cls_pkg::OFS_CTRL, {17'h0, r.ctrl});
        @(posedge clk);
        cp_cmd <= 4'hE;
        @(posedge clk);
        cp_cmd <= 4'h6;
        cyc(4);
        acts("idle", 3'h0);
        chk("fb_en", {31'h0, r.ctrl[8]}, {31'h0, fb_iface_enable});
        @(posedge clk);
        quiet <= r.quiet;
        cyc(6);
        acts("early", 3'h0);
        cyc(5);
        acts("fired", r.exp);
        chk("pset_sel", {30'h0, r.ctrl[14:13]}, {30'h0, pset_sel});
        @(posedge clk);
        quiet <= 4'h0;
        cyc(4);
        acts("restart", 3'h0);
    endtask

    initial begin
        #(20 * 20000);
        failures++;
        finish_test();
    end

    initial begin
        cyc(2);
        chk("ser_en", 32'h1, {31'h0, serial_iface_enable});
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rchk("ctrl", cls_pkg::OFS_CTRL, 32'h50);
        for (int i = 0; i < 4; i++) begin
            rchk("delay", offs[i], {24'h0, dflt[i]});
            wr(offs[i], 32'h0);
            rchk("dmin", offs[i], 32'h1);
            wr(offs[i], 32'hFF);
            rchk("dmax", offs[i], 32'h96);
            wr(offs[i], 32'h2);
        end
        rchk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 19; i++) begin
            run_row(rows[i]);
        end
        // a slow peer inside the delay keeps the timer from expiring, a slower one does not
        wr(cls_pkg::OFS_CTRL, 32'h1404);
        wr(cls_pkg::OFS_STATUS, 32'h1F);
        @(posedge clk);
        gap <= 8'h06;
        for (int i = 0; i < 40; i++) begin
            cyc(1);
            chk("slow_peer", 32'h0, {31'h0, loss_trip});
        end
        @(posedge clk);
        gap <= 8'h0A;
        cyc(40);
        rchk("slower", cls_pkg::OFS_STATUS, 32'h2);
        @(posedge clk);
        gap <= 8'h00;
        cyc(2);
        wr(cls_pkg::OFS_STATUS, 32'h1F);
        rchk("status_clr", cls_pkg::OFS_STATUS, 32'h0);
        @(posedge clk);
        quiet <= 4'h2;
        cyc(12);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rchk("status", cls_pkg::OFS_STATUS, 32'h2);
        rchk("state", cls_pkg::OFS_STATE, 32'h22);
        wr(cls_pkg::OFS_MASK, 32'h2);
        cyc(1);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(cls_pkg::OFS_STATUS, 32'h2);
        cyc(1);
        chk("irq_clr", 32'h0, {31'h0, irq});
        @(posedge clk);
        quiet <= 4'h0;
        for (int i = 0; i < 3; i++) begin
            wr(cls_pkg::OFS_CTRL, 32'h1500 + i);
            @(posedge clk);
            fb_net_error <= 1'b1;
            cyc(2);
            acts("net_err", i == 0 ? 3'h0 : (i == 1 ? 3'h4 : 3'h2));
            @(posedge clk);
            fb_net_error <= 1'b0;
            cyc(2);
        end
        wr(cls_pkg::OFS_STATUS, 32'h1F);
        wr(cls_pkg::OFS_CTRL, 32'h0200);
        @(posedge clk);
        drive_running <= 1'b1;
        quiet <= 4'h4;
        cyc(3);
        chk("stop", 32'h1, {31'h0, stop_request});
        rchk("stop_status", cls_pkg::OFS_STATUS, 32'h10);
        @(posedge clk);
        drive_running <= 1'b0;
        cyc(3);
        chk("stop_idle", 32'h0, {31'h0, stop_request});
        // panel supervision stays quiet until a command write arms it
        wr(cls_pkg::OFS_CTRL, 32'h1440);
        @(posedge clk);
        quiet <= 4'h8;
        cyc(12);
        acts("cp_unarmed", 3'h0);
        @(posedge clk);
        cp_cmd <= 4'hD;
        @(posedge clk);
        cp_cmd <= 4'h5;
        cyc(12);
        acts("cp_left", 3'h4);
        @(posedge clk);
        quiet <= 4'h0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rchk("ctrl_rst", cls_pkg::OFS_CTRL, 32'h50);
        cyc(1);
        chk("rdata_idle", 32'h0, reg_rdata);
        finish_test();
    end
endmodule

// *** design/cls_pkg.sv ***
// package: constants, register map and carrier types of the communication loss supervisor
package cls_pkg;
    // timing: delays are held in units of 0.1 s
    localparam int CLK_PERIOD_NS = 20;
    localparam int DELAY_UNIT_NS = 100_000_000;
    localparam int TICK_CYCLES = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int AW = 8;
    localparam int DW = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FB_DELAY = 8'h04;
    localparam logic [7:0] OFS_SER_DELAY = 8'h08;
    localparam logic [7:0] OFS_KPD_DELAY = 8'h0C;
    localparam logic [7:0] OFS_CP_DELAY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1C;

    // delay limits and reset values, in 0.1 s units
    localparam logic [7:0] DELAY_MIN = 8'h01;
    localparam logic [7:0] DELAY_MAX = 8'h96;
    localparam logic [7:0] RST_FB_DELAY = 8'h05;
    localparam logic [7:0] RST_SER_DELAY = 8'h05;
    localparam logic [7:0] RST_KPD_DELAY = 8'h14;
    localparam logic [7:0] RST_CP_DELAY = 8'h64;

    // status / mask bit positions
    localparam int ST_FB = 0;
    localparam int ST_SER = 1;
    localparam int ST_KPD = 2;
    localparam int ST_CP = 3;
    localparam int ST_STOP = 4;
    localparam int ST_W = 5;
    localparam int CFG_W = 15;

    typedef enum logic [1:0] {
        CLS_ACT_OFF = 2'h0,
        CLS_ACT_TRIP = 2'h1,
        CLS_ACT_WARN = 2'h2,
        CLS_ACT_PSET = 2'h3
    } cls_action_t;

    typedef enum logic [1:0] {
        CLS_SRC_REMOTE = 2'h0,
        CLS_SRC_KEYPAD = 2'h1,
        CLS_SRC_COM = 2'h2,
        CLS_SRC_RSVD = 2'h3
    } cls_src_t;

    // control register layout, lsb first: fb, serial, keypad, panel actions, then the rest
    typedef struct packed {
        logic [1:0] pset_sel;
        cls_src_t run_src;
        cls_src_t ref_src;
        logic comm_type;
        cls_action_t panel_port_loss_action;
        cls_action_t keypad_loss_action;
        cls_action_t serial_loss_action;
        cls_action_t fieldbus_loss_action;
    } cls_cfg_t;

    localparam cls_cfg_t RST_CFG = '{
        pset_sel: 2'h0,
        run_src: CLS_SRC_REMOTE,
        ref_src: CLS_SRC_REMOTE,
        comm_type: 1'b0,
        panel_port_loss_action: CLS_ACT_TRIP,
        keypad_loss_action: CLS_ACT_TRIP,
        serial_loss_action: CLS_ACT_OFF,
        fieldbus_loss_action: CLS_ACT_OFF
    };

    // panel-port command register activity
    typedef struct packed {
        logic write;
        logic run;
        logic run_direction_right_cmd;
        logic run_direction_left_cmd;
    } cls_cp_cmd_t;
endpackage

// *** design/cls_supervisor.sv ***
// communication loss supervisor: four silence timers, action decode, registers and interrupt
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module cls_loss_timer #(
    parameter int TICK_CYCLES = cls_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic arm,
    input wire logic activity,
    input wire logic [7:0] delay,
    output logic expired
);
    localparam int SW = $clog2(TICK_CYCLES + 1);
    localparam logic [SW-1:0] SUB_LAST = SW'(TICK_CYCLES - 1);

    logic [SW-1:0] sub_q;
    logic [7:0] tenth_q;

    // silence is measured from the last activity, so the fire time has no tick jitter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sub_q <= '0;
            tenth_q <= 8'h00;
        end else if (!arm || activity) begin
            sub_q <= '0;
            tenth_q <= 8'h00;
        end else if (tenth_q < delay) begin
            if (sub_q == SUB_LAST) begin
                sub_q <= '0;
                tenth_q <= tenth_q + 8'h01;
            end else begin
                sub_q <= sub_q + SW'(1);
            end
        end
    end

    assign expired = arm && (delay != 8'h00) && (tenth_q >= delay);

    a_timer_restart: assert property (@(posedge clk) disable iff (sys_rst)
        activity |=> (tenth_q == 8'h00) && !expired)
        else $error("timer did not restart on activity");
    a_timer_fire_step: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(expired) && $stable(delay) && arm |-> $past(sub_q) == SUB_LAST)
        else $error("timer fired off a tick boundary");
endmodule

module cls_supervisor #(
    parameter int TICK_CYCLES = cls_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic fb_activity,
    input wire logic fb_net_error,
    input wire logic serial_activity,
    input wire logic keypad_present,
    input wire logic cp_activity,
    input wire cls_pkg::cls_cp_cmd_t cp_cmd,
    input wire logic drive_running,
    output logic fb_iface_enable,
    output logic serial_iface_enable,
    output logic loss_trip,
    output logic loss_warning,
    output logic pset_change,
    output logic [1:0] pset_sel,
    output logic stop_request,
    output logic irq
);
    cls_pkg::cls_cfg_t cfg_q;
    logic [7:0] fb_delay_q;
    logic [7:0] ser_delay_q;
    logic [7:0] kpd_delay_q;
    logic [7:0] cp_delay_q;
    logic [cls_pkg::ST_W-1:0] status_q;
    logic [cls_pkg::ST_W-1:0] mask_q;
    logic [31:0] rdata_q;
    logic cp_written_q;
    logic trip_q;
    logic warn_q;
    logic pset_q;
    logic stop_q;
    logic fb_en_q;
    logic [3:0] fault_q;

    logic com_src;
    logic kpd_src;
    logic fb_on;
    logic ser_on;
    logic kpd_on;
    logic cp_on;
    logic fb_exp;
    logic ser_exp;
    logic kpd_exp;
    logic cp_exp;
    logic [3:0] fault;
    cls_pkg::cls_action_t act [4];
    logic [3:0] is_trip;
    logic [3:0] is_warn;
    logic [3:0] is_pset;
    logic stop_d;
    logic [cls_pkg::ST_W-1:0] events;
    logic [7:0] wr_delay;

    function automatic logic [7:0] clamp_delay(input logic [7:0] v);
        if (v < cls_pkg::DELAY_MIN) begin
            return cls_pkg::DELAY_MIN;
        end else if (v > cls_pkg::DELAY_MAX) begin
            return cls_pkg::DELAY_MAX;
        end
        return v;
    endfunction

    assign wr_delay = clamp_delay(reg_wdata[7:0]);

    // supervision enables
    assign com_src = (cfg_q.ref_src == cls_pkg::CLS_SRC_COM)
        || (cfg_q.run_src == cls_pkg::CLS_SRC_COM);
    assign kpd_src = (cfg_q.ref_src == cls_pkg::CLS_SRC_KEYPAD)
        || (cfg_q.run_src == cls_pkg::CLS_SRC_KEYPAD);
    assign fb_on = (cfg_q.fieldbus_loss_action != cls_pkg::CLS_ACT_OFF)
        && cfg_q.comm_type && com_src;
    assign ser_on = (cfg_q.serial_loss_action != cls_pkg::CLS_ACT_OFF) && com_src;
    // keypad code 3 is outside the selector and is treated as off
    assign kpd_on = (cfg_q.keypad_loss_action == cls_pkg::CLS_ACT_TRIP)
        || (cfg_q.keypad_loss_action == cls_pkg::CLS_ACT_WARN);
    assign cp_on = com_src && cp_written_q && cp_cmd.run
        && (cp_cmd.run_direction_right_cmd || cp_cmd.run_direction_left_cmd)
        && (cfg_q.panel_port_loss_action != cls_pkg::CLS_ACT_OFF);

    // the written flag only makes sense while communication owns control
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cp_written_q <= 1'b0;
        end else if (!com_src) begin
            cp_written_q <= 1'b0;
        end else if (cp_cmd.write) begin
            cp_written_q <= 1'b1;
        end
    end

    cls_loss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_fb_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(fb_on),
        .activity(fb_activity),
        .delay(fb_delay_q),
        .expired(fb_exp)
    );
    cls_loss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_ser_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(ser_on),
        .activity(serial_activity),
        .delay(ser_delay_q),
        .expired(ser_exp)
    );
    // presence counts as activity: the timer only runs while the keypad is gone
    cls_loss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_kpd_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(kpd_on),
        .activity(keypad_present),
        .delay(kpd_delay_q),
        .expired(kpd_exp)
    );
    cls_loss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_cp_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .arm(cp_on),
        .activity(cp_activity),
        .delay(cp_delay_q),
        .expired(cp_exp)
    );

    assign fault[cls_pkg::ST_FB] = fb_on && (fb_exp || fb_net_error);
    assign fault[cls_pkg::ST_SER] = ser_exp;
    assign fault[cls_pkg::ST_KPD] = kpd_exp;
    assign fault[cls_pkg::ST_CP] = cp_exp;

    assign act[0] = cfg_q.fieldbus_loss_action;
    assign act[1] = cfg_q.serial_loss_action;
    assign act[2] = cfg_q.keypad_loss_action;
    assign act[3] = cfg_q.panel_port_loss_action;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            is_trip[i] = (act[i] == cls_pkg::CLS_ACT_TRIP);
            is_warn[i] = (act[i] == cls_pkg::CLS_ACT_WARN)
                || ((act[i] == cls_pkg::CLS_ACT_PSET) && (i != 2));
            is_pset[i] = (act[i] == cls_pkg::CLS_ACT_PSET) && (i != 2);
        end
    end

    assign stop_d = !keypad_present && drive_running && kpd_src;

    // action outputs are level: they stand while the loss condition stands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trip_q <= 1'b0;
            warn_q <= 1'b0;
            pset_q <= 1'b0;
            stop_q <= 1'b0;
            fault_q <= 4'h0;
        end else begin
            trip_q <= |(fault & is_trip);
            warn_q <= |(fault & is_warn);
            pset_q <= |(fault & is_pset);
            stop_q <= stop_d;
            fault_q <= fault;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fb_en_q <= 1'b0;
        end else begin
            fb_en_q <= cfg_q.comm_type;
        end
    end

    assign loss_trip = trip_q;
    assign loss_warning = warn_q;
    assign pset_change = pset_q;
    assign pset_sel = cfg_q.pset_sel;
    assign stop_request = stop_q;
    assign fb_iface_enable = fb_en_q;
    assign serial_iface_enable = 1'b1;

    // configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= cls_pkg::RST_CFG;
            fb_delay_q <= cls_pkg::RST_FB_DELAY;
            ser_delay_q <= cls_pkg::RST_SER_DELAY;
            kpd_delay_q <= cls_pkg::RST_KPD_DELAY;
            cp_delay_q <= cls_pkg::RST_CP_DELAY;
            mask_q <= '0;
        end else if (reg_wr) begin
            if (reg_addr == cls_pkg::OFS_CTRL) begin
                cfg_q <= cls_pkg::cls_cfg_t'(reg_wdata[cls_pkg::CFG_W-1:0]);
            end else if (reg_addr == cls_pkg::OFS_FB_DELAY) begin
                fb_delay_q <= wr_delay;
            end else if (reg_addr == cls_pkg::OFS_SER_DELAY) begin
                ser_delay_q <= wr_delay;
            end else if (reg_addr == cls_pkg::OFS_KPD_DELAY) begin
                kpd_delay_q <= wr_delay;
            end else if (reg_addr == cls_pkg::OFS_CP_DELAY) begin
                cp_delay_q <= wr_delay;
            end else if (reg_addr == cls_pkg::OFS_MASK) begin
                mask_q <= reg_wdata[cls_pkg::ST_W-1:0];
            end
        end
    end

    // sticky events on rising faults; a new event beats a write-one-to-clear
    assign events = {stop_d && !stop_q, fault & ~fault_q};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= '0;
        end else if (reg_wr && (reg_addr == cls_pkg::OFS_STATUS)) begin
            status_q <= (status_q & ~reg_wdata[cls_pkg::ST_W-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    assign irq = |(status_q & mask_q);

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (!reg_rd) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_addr == cls_pkg::OFS_CTRL) begin
            rdata_q <= 32'(cfg_q);
        end else if (reg_addr == cls_pkg::OFS_FB_DELAY) begin
            rdata_q <= 32'(fb_delay_q);
        end else if (reg_addr == cls_pkg::OFS_SER_DELAY) begin
            rdata_q <= 32'(ser_delay_q);
        end else if (reg_addr == cls_pkg::OFS_KPD_DELAY) begin
            rdata_q <= 32'(kpd_delay_q);
        end else if (reg_addr == cls_pkg::OFS_CP_DELAY) begin
            rdata_q <= 32'(cp_delay_q);
        end else if (reg_addr == cls_pkg::OFS_STATUS) begin
            rdata_q <= 32'(status_q);
        end else if (reg_addr == cls_pkg::OFS_MASK) begin
            rdata_q <= 32'(mask_q);
        end else if (reg_addr == cls_pkg::OFS_STATE) begin
            rdata_q <= 32'({pset_q, warn_q, trip_q, cp_on, fault_q});
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // checks
    sequence s_fb_net_loss;
        fb_net_error && fb_on;
    endsequence
    sequence s_fb_trip_cfg;
        cfg_q.fieldbus_loss_action == cls_pkg::CLS_ACT_TRIP;
    endsequence

    a_fb_net_trip: assert property (@(posedge clk) disable iff (sys_rst)
        s_fb_net_loss and s_fb_trip_cfg |=> loss_trip)
        else $error("network error in trip action gave no trip");
    a_fb_net_warn: assert property (@(posedge clk) disable iff (sys_rst)
        s_fb_net_loss ##0 cfg_q.fieldbus_loss_action == cls_pkg::CLS_ACT_WARN
        |=> loss_warning && !pset_change)
        else $error("network error in warning action gave no warning");
    a_pset_with_warn: assert property (@(posedge clk) disable iff (sys_rst)
        pset_change |-> loss_warning && !$past(sys_rst))
        else $error("set change without warning");
    a_fb_needs_com: assert property (@(posedge clk) disable iff (sys_rst)
        !com_src |-> !fault[cls_pkg::ST_FB] && !fault[cls_pkg::ST_SER])
        else $error("fieldbus or serial fault without communication source");
    a_delay_range: assert property (@(posedge clk) disable iff (sys_rst)
        fb_delay_q inside {[cls_pkg::DELAY_MIN:cls_pkg::DELAY_MAX]}
        && ser_delay_q inside {[cls_pkg::DELAY_MIN:cls_pkg::DELAY_MAX]}
        && kpd_delay_q inside {[cls_pkg::DELAY_MIN:cls_pkg::DELAY_MAX]}
        && cp_delay_q inside {[cls_pkg::DELAY_MIN:cls_pkg::DELAY_MAX]})
        else $error("delay left its programmable range");
    a_kpd_stop: assert property (@(posedge clk) disable iff (sys_rst)
        !keypad_present && drive_running && kpd_src |=> stop_request)
        else $error("keypad removal under keypad control did not stop the drive");
    a_cp_arming: assert property (@(posedge clk) disable iff (sys_rst)
        fault[cls_pkg::ST_CP] |-> cp_written_q && com_src && cp_cmd.run)
        else $error("panel fault while supervision not armed");
    a_off_silent: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_q.serial_loss_action == cls_pkg::CLS_ACT_OFF)
        && (cfg_q.fieldbus_loss_action == cls_pkg::CLS_ACT_OFF)
        && (cfg_q.keypad_loss_action == cls_pkg::CLS_ACT_OFF)
        && (cfg_q.panel_port_loss_action == cls_pkg::CLS_ACT_OFF)
        ##1 $stable(cfg_q) |-> !loss_trip && !loss_warning && !pset_change)
        else $error("off supervisors raised an action");
    a_fb_iface: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(cfg_q.comm_type) |=> fb_iface_enable == $past(cfg_q.comm_type))
        else $error("option interface enable does not follow comm type");
    a_read_once: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
endmodule
